// ==== rtl/line_input_sampler.sv ====
`timescale 1ns/10ps
`default_nettype none
module line_input_sampler
  import port_line_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [LINE_PIN_COUNT-1:0] pins_in,
  output logic [LINE_PIN_COUNT-1:0] pins_sync
);

  typedef struct packed {
    logic [LINE_PIN_COUNT-1:0] stage1;
    logic [LINE_PIN_COUNT-1:0] stage2;
  } sampler_state_type;

  sampler_state_type s_ff;
  sampler_state_type nxt_s;

  // The first stage feeds only the second, so a metastable level never reaches any logic.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.stage1 = pins_in;
    nxt_s.stage2 = s_ff.stage1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pins_sync = s_ff.stage2;

endmodule : line_input_sampler
`default_nettype wire

// ==== rtl/port_line_pkg.sv ====
// Summary of operation
// R1 - Writing 1 to the full reset bit resets every port state machine and returns all other port control registers to their defaults.
// R2 - A full reset returns only bits 0 to 6 of the port mode register to default and leaves the full reset bit as written.
// R3 - Writing 1 to the state reset bit resets every port state machine and leaves all readable and writable port registers unaltered.
// R4 - While the state reset is active every port output is released to high impedance.
// R5 - With source loopback set, the transmit clock and data are routed internally onto the receive clock and data.
// R6 - While source loopback is active the port behaves as general purpose mode whatever the interface select field holds.
// R7 - With far-end loopback set, received line data is passed through the receive processing and returned into the transmit path.
// R8 - The interface select field codes 000 T1, 001 E1, 101 general purpose, 110 DSL and 111 power down, the rest are reserved.
// R9 - In general purpose mode both the receive sync and the transmit sync inputs are disregarded.
// R10 - Software changes the loopback bits, the interface select field and the line polarity bits only while a reset is asserted.
// R11 - The receive sync input is active high when its polarity bit is 1 and active low when it is 0.
// R12 - The receive clock is sampled on its falling edge when its edge select bit is 1 and on its rising edge when it is 0.
// R13 - The transmit sync input is active high when its polarity bit is 1 and active low when it is 0.
// R14 - The transmit clock acts on its falling edge when its edge select bit is 1 and on its rising edge when it is 0.
// R15 - Software writes the full reset bit back to 0 to release the port from full reset.
package port_line_pkg;

  localparam logic [7:0] PORT_MODE_IDX = 8'h04;
  localparam logic [7:0] LINE_IO_IDX = 8'h05;
  localparam logic [7:0] PORT_MODE_ADDR = {PORT_MODE_IDX[5:0], 2'b00};
  localparam logic [7:0] LINE_IO_ADDR = {LINE_IO_IDX[5:0], 2'b00};

  localparam logic [7:0] PORT_MODE_DEFAULT = 8'h00;
  localparam logic [7:0] LINE_IO_DEFAULT = 8'h00;
  localparam logic [7:0] PORT_MODE_WMASK = 8'hf7;
  localparam logic [7:0] LINE_IO_WMASK = 8'h78;
  localparam logic [23:0] READ_PAD = 24'h000000;

  localparam int FULL_RESET_BIT = 7;
  localparam int STATE_RESET_BIT = 6;
  localparam int SRC_LOOP_BIT = 5;
  localparam int FE_LOOP_BIT = 4;
  localparam int RX_SYNC_POL_BIT = 6;
  localparam int RX_EDGE_SEL_BIT = 5;
  localparam int TX_SYNC_POL_BIT = 4;
  localparam int TX_EDGE_SEL_BIT = 3;

  typedef enum logic [2:0] {
    MODE_T1 = 3'h0,
    MODE_E1 = 3'h1,
    MODE_RSVD_2 = 3'h2,
    MODE_RSVD_3 = 3'h3,
    MODE_RSVD_4 = 3'h4,
    MODE_GP = 3'h5,
    MODE_DSL = 3'h6,
    MODE_POWER_DOWN = 3'h7
  } line_mode_type;

  localparam int LINE_PIN_COUNT = 5;
  localparam int PIN_RX_CLK = 0;
  localparam int PIN_RX_DATA = 1;
  localparam int PIN_RX_SYNC = 2;
  localparam int PIN_TX_CLK = 3;
  localparam int PIN_TX_SYNC = 4;

  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_STEP = 3'h1;

endpackage : port_line_pkg

// ==== rtl/port_mode_line_config.sv ====
`timescale 1ns/10ps
`default_nettype none
module port_mode_line_config
  import port_line_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic line_rx_clock_in,
  input wire logic line_rx_data_in,
  input wire logic line_rx_sync_in,
  input wire logic line_tx_clock_in,
  input wire logic line_tx_sync_in,
  input wire logic [7:0] tx_byte_in,
  output logic tx_byte_taken,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  output logic line_tx_data_out,
  output logic line_tx_data_oe,
  output logic [2:0] line_mode_active
);

  typedef struct packed {
    logic [7:0] port_mode_control;
    logic [7:0] line_io_mode_control;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic rx_clk_prev;
    logic tx_clk_prev;
    logic [7:0] rx_shift;
    logic [2:0] rx_count;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic [7:0] tx_shift;
    logic [2:0] tx_count;
    logic tx_data;
    logic tx_oe;
    logic tx_taken;
    logic [7:0] loop_byte;
    logic [2:0] mode;
  } port_state_type;

  localparam port_state_type STATE_INIT = '{
    port_mode_control: PORT_MODE_DEFAULT,
    line_io_mode_control: LINE_IO_DEFAULT,
    mode: MODE_T1,
    default: '0
  };

  port_state_type s_ff;
  port_state_type nxt_s;

  logic [LINE_PIN_COUNT-1:0] pins_sync;
  logic [2:0] eff_mode;
  logic use_sync;
  logic port_hold;
  logic rx_clk_now;
  logic rx_bit;
  logic rx_edge;
  logic tx_edge;
  logic rx_sync_hit;
  logic tx_sync_hit;
  logic tx_load;
  logic apb_setup;
  logic apb_done;
  logic wr_port_mode;
  logic wr_line_io;

  line_input_sampler u_sampler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pins_in({line_tx_sync_in, line_tx_clock_in, line_rx_sync_in, line_rx_data_in,
              line_rx_clock_in}),
    .pins_sync(pins_sync)
  );

  function automatic logic addr_hits(input logic [7:0] addr, input logic [7:0] reg_addr);
    addr_hits = (addr == reg_addr);
  endfunction : addr_hits

  // A falling edge is chosen when the select bit is 1, a rising edge otherwise.
  function automatic logic active_edge(input logic now, input logic prev, input logic fall_sel);
    active_edge = fall_sel ? (prev && !now) : (now && !prev);
  endfunction : active_edge

  function automatic logic sync_active(input logic level, input logic high_active);
    sync_active = (level == high_active);
  endfunction : sync_active

  // Reserved codes keep the line idle, like power down, since no behaviour is defined for them.
  function automatic logic mode_runs(input logic [2:0] mode);
    mode_runs = (mode == MODE_T1) || (mode == MODE_E1) || (mode == MODE_GP) ||
                (mode == MODE_DSL);
  endfunction : mode_runs

  assign eff_mode = s_ff.port_mode_control[SRC_LOOP_BIT] ? MODE_GP :
                    s_ff.port_mode_control[2:0]; // R6 R8
  assign use_sync = (eff_mode != MODE_GP); // R9
  assign port_hold = s_ff.port_mode_control[FULL_RESET_BIT] ||
                     s_ff.port_mode_control[STATE_RESET_BIT]; // R1 R3
  assign rx_clk_now = s_ff.port_mode_control[SRC_LOOP_BIT] ? pins_sync[PIN_TX_CLK] :
                      pins_sync[PIN_RX_CLK]; // R5
  assign rx_bit = s_ff.port_mode_control[SRC_LOOP_BIT] ? s_ff.tx_data :
                  pins_sync[PIN_RX_DATA]; // R5
  assign rx_edge = active_edge(rx_clk_now, s_ff.rx_clk_prev,
                               s_ff.line_io_mode_control[RX_EDGE_SEL_BIT]); // R12
  assign tx_edge = active_edge(pins_sync[PIN_TX_CLK], s_ff.tx_clk_prev,
                               s_ff.line_io_mode_control[TX_EDGE_SEL_BIT]); // R14
  assign rx_sync_hit = use_sync && sync_active(pins_sync[PIN_RX_SYNC],
                       s_ff.line_io_mode_control[RX_SYNC_POL_BIT]); // R9 R11
  assign tx_sync_hit = use_sync && sync_active(pins_sync[PIN_TX_SYNC],
                       s_ff.line_io_mode_control[TX_SYNC_POL_BIT]); // R9 R13
  assign tx_load = tx_edge && ((s_ff.tx_count == BIT_FIRST) || tx_sync_hit);
  assign apb_setup = psel && !penable;
  assign apb_done = psel && penable && s_ff.pready;
  assign wr_port_mode = apb_done && pwrite && addr_hits(paddr, PORT_MODE_ADDR);
  assign wr_line_io = apb_done && pwrite && addr_hits(paddr, LINE_IO_ADDR);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.pready = apb_setup;
    nxt_s.pslverr = 1'b0;
    nxt_s.prdata = '0;
    if (apb_setup) begin
      if (addr_hits(paddr, PORT_MODE_ADDR)) begin
        nxt_s.prdata = {READ_PAD, s_ff.port_mode_control};
      end else if (addr_hits(paddr, LINE_IO_ADDR)) begin
        nxt_s.prdata = {READ_PAD, s_ff.line_io_mode_control};
      end else begin
        nxt_s.pslverr = 1'b1;
      end
    end

    if (wr_port_mode) begin
      nxt_s.port_mode_control = pwdata[7:0] & PORT_MODE_WMASK;
    end
    if (wr_line_io) begin
      nxt_s.line_io_mode_control = pwdata[7:0] & LINE_IO_WMASK;
    end
    // Full reset keeps its own bit and pins the rest at default until software clears it.
    if (nxt_s.port_mode_control[FULL_RESET_BIT]) begin
      nxt_s.port_mode_control[6:0] = PORT_MODE_DEFAULT[6:0]; // R1 R2 R15
      nxt_s.line_io_mode_control = LINE_IO_DEFAULT; // R1
    end

    nxt_s.rx_clk_prev = rx_clk_now;
    nxt_s.tx_clk_prev = pins_sync[PIN_TX_CLK];
    nxt_s.rx_valid = 1'b0;
    nxt_s.tx_taken = 1'b0;
    nxt_s.mode = eff_mode;
    nxt_s.tx_oe = !port_hold && mode_runs(eff_mode); // R4

    if (port_hold) begin
      nxt_s.rx_shift = '0; // R1 R3
      nxt_s.rx_count = BIT_FIRST;
      nxt_s.rx_byte = '0;
      nxt_s.tx_shift = '0;
      nxt_s.tx_count = BIT_FIRST;
      nxt_s.tx_data = 1'b0;
      nxt_s.loop_byte = '0;
    end else if (mode_runs(eff_mode)) begin
      if (rx_edge) begin
        nxt_s.rx_shift = {s_ff.rx_shift[6:0], rx_bit};
        if (rx_sync_hit) begin
          nxt_s.rx_count = BIT_STEP;
        end else if (s_ff.rx_count == BIT_LAST) begin
          nxt_s.rx_count = BIT_FIRST;
          nxt_s.rx_byte = {s_ff.rx_shift[6:0], rx_bit};
          nxt_s.loop_byte = {s_ff.rx_shift[6:0], rx_bit}; // R7
          nxt_s.rx_valid = 1'b1;
        end else begin
          nxt_s.rx_count = 3'(s_ff.rx_count + BIT_STEP);
        end
      end
      if (tx_load) begin
        if (s_ff.port_mode_control[FE_LOOP_BIT]) begin
          nxt_s.tx_data = s_ff.loop_byte[7]; // R7
          nxt_s.tx_shift = {s_ff.loop_byte[6:0], 1'b0};
        end else begin
          nxt_s.tx_data = tx_byte_in[7];
          nxt_s.tx_shift = {tx_byte_in[6:0], 1'b0};
          nxt_s.tx_taken = 1'b1;
        end
        nxt_s.tx_count = BIT_STEP;
      end else if (tx_edge) begin
        nxt_s.tx_data = s_ff.tx_shift[7];
        nxt_s.tx_shift = {s_ff.tx_shift[6:0], 1'b0};
        nxt_s.tx_count = (s_ff.tx_count == BIT_LAST) ? BIT_FIRST : 3'(s_ff.tx_count + BIT_STEP);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= STATE_INIT;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pready = s_ff.pready;
  assign prdata = s_ff.prdata;
  assign pslverr = s_ff.pslverr;
  assign tx_byte_taken = s_ff.tx_taken;
  assign rx_byte = s_ff.rx_byte;
  assign rx_byte_valid = s_ff.rx_valid;
  assign line_tx_data_out = s_ff.tx_data;
  assign line_tx_data_oe = s_ff.tx_oe;
  assign line_mode_active = s_ff.mode;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence full_reset_write_s;
    wr_port_mode && pwdata[FULL_RESET_BIT];
  endsequence

  sequence port_at_default_s;
    s_ff.port_mode_control[FULL_RESET_BIT] &&
    (s_ff.port_mode_control[6:0] == PORT_MODE_DEFAULT[6:0]) &&
    (s_ff.line_io_mode_control == LINE_IO_DEFAULT);
  endsequence

  full_reset_defaults_a: assert property (full_reset_write_s |=> port_at_default_s) // R1
    else $error("Full reset did not restore the port defaults.");

  full_reset_sticks_a: assert property (
    s_ff.port_mode_control[FULL_RESET_BIT] && !wr_port_mode |=> port_at_default_s) // R2
    else $error("Full reset bit or held defaults changed without a write.");

  state_reset_keeps_a: assert property (
    s_ff.port_mode_control[STATE_RESET_BIT] && !s_ff.port_mode_control[FULL_RESET_BIT] &&
    !wr_line_io |=> $stable(s_ff.line_io_mode_control)) // R3
    else $error("State reset altered the line mode register.");

  state_reset_clears_a: assert property ( // R3
    port_hold |=> (s_ff.rx_count == BIT_FIRST) && (s_ff.tx_count == BIT_FIRST) && !rx_byte_valid)
    else $error("Port state machines not reset during port reset.");

  output_release_a: assert property (
    s_ff.port_mode_control[STATE_RESET_BIT] |=> !line_tx_data_oe) // R4
    else $error("Line output driven during state reset.");

  source_loop_data_a: assert property (
    s_ff.port_mode_control[SRC_LOOP_BIT] |-> (rx_bit == line_tx_data_out) &&
    (rx_clk_now == pins_sync[PIN_TX_CLK])) // R5
    else $error("Source loopback not routing transmit onto receive.");

  source_loop_mode_a: assert property (
    s_ff.port_mode_control[SRC_LOOP_BIT] && !port_hold |=> line_mode_active == MODE_GP) // R6
    else $error("Source loopback did not force general purpose mode.");

  far_end_loop_a: assert property (
    tx_load && !port_hold && mode_runs(eff_mode) && s_ff.port_mode_control[FE_LOOP_BIT]
    |=> (line_tx_data_out == $past(s_ff.loop_byte[7])) && !tx_byte_taken) // R7
    else $error("Far-end loopback did not send the received byte.");

  mode_decode_a: assert property ( // R8
    !s_ff.port_mode_control[SRC_LOOP_BIT] |=>
    line_mode_active == $past(s_ff.port_mode_control[2:0]))
    else $error("Interface select field not decoded.");

  general_sync_ignored_a: assert property (
    eff_mode == MODE_GP |-> !rx_sync_hit && !tx_sync_hit) // R9
    else $error("Sync input honoured in general purpose mode.");

  rx_sync_level_a: assert property (
    rx_sync_hit |-> pins_sync[PIN_RX_SYNC] == s_ff.line_io_mode_control[RX_SYNC_POL_BIT]) // R11
    else $error("Receive sync taken at the wrong level.");

  rx_edge_select_a: assert property (
    rx_edge |-> (rx_clk_now != s_ff.rx_clk_prev) &&
    (rx_clk_now == !s_ff.line_io_mode_control[RX_EDGE_SEL_BIT])) // R12
    else $error("Receive clock sampled on the wrong edge.");

  tx_sync_level_a: assert property (
    tx_sync_hit |-> pins_sync[PIN_TX_SYNC] == s_ff.line_io_mode_control[TX_SYNC_POL_BIT]) // R13
    else $error("Transmit sync taken at the wrong level.");

  tx_edge_select_a: assert property (
    tx_edge |-> ($past(pins_sync[PIN_TX_CLK]) != pins_sync[PIN_TX_CLK]) &&
    (pins_sync[PIN_TX_CLK] == !s_ff.line_io_mode_control[TX_EDGE_SEL_BIT])) // R14
    else $error("Transmit clock acted on the wrong edge.");

  apb_answer_a: assert property (apb_setup |=> pready ##1 !pready || apb_setup)
    else $error("Bus answer not given in the first access cycle.");

  full_reset_quiet_a: assert property ( // R1
    s_ff.port_mode_control[FULL_RESET_BIT] |=> !line_tx_data_oe && !rx_byte_valid)
    else $error("Line port active during full reset.");

  idle_mode_quiet_a: assert property ( // R8
    !mode_runs(eff_mode) |=> !line_tx_data_oe && !rx_byte_valid && !tx_byte_taken)
    else $error("Line port active in power down or a reserved mode.");

  hold_no_traffic_a: assert property ( // R3
    port_hold |=> !tx_byte_taken && (line_tx_data_out == 1'b0))
    else $error("Line traffic during port reset.");

  unmapped_error_a: assert property (
    apb_setup && !addr_hits(paddr, PORT_MODE_ADDR) && !addr_hits(paddr, LINE_IO_ADDR)
    |=> pready && pslverr && (prdata == '0))
    else $error("Unmapped access not answered with an error.");

  bus_idle_clear_a: assert property (
    !pready |-> (prdata == '0) && !pslverr)
    else $error("Read data or error standing outside the access cycle.");

  rx_valid_pulse_a: assert property (
    rx_byte_valid |=> !rx_byte_valid)
    else $error("Receive valid held longer than one cycle.");

  tx_taken_pulse_a: assert property (
    tx_byte_taken |=> !tx_byte_taken)
    else $error("Transmit byte taken held longer than one cycle.");

endmodule : port_mode_line_config
`default_nettype wire

// ==== test/line_framer_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module line_framer_model (
  input wire logic clk_sys,
  input wire logic line_tx_data_out,
  output logic line_rx_clock_in,
  output logic line_rx_data_in,
  output logic line_rx_sync_in,
  output logic line_tx_clock_in,
  output logic line_tx_sync_in
);
  // The port needs the line clocks slower than a quarter of clk_sys, so a half is 8 cycles.
  localparam int HALF = 8;
  logic [7:0] tx_seen;
  initial begin
    line_rx_clock_in = 1'b0;
    line_rx_data_in = 1'b0;
    line_rx_sync_in = 1'b1;
    line_tx_clock_in = 1'b0;
    line_tx_sync_in = 1'b1;
    tx_seen = 8'h00;
  end
  task automatic half_wait();
    repeat (HALF) @(posedge clk_sys);
  endtask : half_wait
  // Clocks idle at the inactive level so each bit opens with its active edge.
  // Data flips at the inactive edge, so a port that picks the wrong edge reads the inverse.
  task automatic send_rx(input logic [7:0] b, input int sync_at, input logic pol,
                         input logic fall);
    line_rx_clock_in <= fall;
    half_wait();
    for (int i = 0; i < 8; i++) begin
      line_rx_data_in <= b[7-i];
      line_rx_sync_in <= (i == sync_at) ? pol : ~pol;
      half_wait();
      line_rx_clock_in <= ~fall;
      half_wait();
      line_rx_data_in <= ~b[7-i];
      line_rx_clock_in <= fall;
      half_wait();
    end
    line_rx_sync_in <= ~pol;
  endtask : send_rx
  // Sampling between the active and the inactive edge catches a port that shifts on the wrong one.
  task automatic run_tx(input int sync_at, input logic pol, input logic fall);
    line_tx_clock_in <= fall;
    half_wait();
    for (int i = 0; i < 8; i++) begin
      line_tx_sync_in <= (i == sync_at) ? pol : ~pol;
      half_wait();
      line_tx_clock_in <= ~fall;
      half_wait();
      tx_seen[7-i] = line_tx_data_out;
      line_tx_clock_in <= fall;
      half_wait();
    end
    line_tx_sync_in <= ~pol;
  endtask : run_tx
endmodule : line_framer_model
`default_nettype wire

// ==== test/port_mode_line_interface_config_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module port_mode_line_interface_config_tb
  import port_line_pkg::*;
;
  localparam int LIMIT = 20000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0] tx_byte_in = 8'h00;
  logic pready, pslverr, rx_byte_valid, line_tx_data_out, line_tx_data_oe;
  logic [31:0] prdata;
  logic [7:0] rx_byte;
  logic [2:0] line_mode_active;
  logic rx_clk, rx_dat, rx_syn, tx_clk, tx_syn;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  logic tx_taken;
  int n_taken = 0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (tx_taken === 1'b1) begin
      n_taken <= n_taken + 1;
    end
  end
  port_mode_line_config port_mode_line_config_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .line_rx_clock_in(rx_clk), .line_rx_data_in(rx_dat), .line_rx_sync_in(rx_syn),
    .line_tx_clock_in(tx_clk), .line_tx_sync_in(tx_syn), .tx_byte_in(tx_byte_in),
    .tx_byte_taken(tx_taken), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
    .line_tx_data_out(line_tx_data_out), .line_tx_data_oe(line_tx_data_oe),
    .line_mode_active(line_mode_active)
  );
  line_framer_model line_framer_model_i (
    .clk_sys(clk_sys), .line_tx_data_out(line_tx_data_out), .line_rx_clock_in(rx_clk),
    .line_rx_data_in(rx_dat), .line_rx_sync_in(rx_syn), .line_tx_clock_in(tx_clk),
    .line_tx_sync_in(tx_syn)
  );
  task automatic summarize();
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] exp, input logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    chk(32'(pready), 32'h1);
    if (!w) chk(prdata, {24'h000000, exp});
    chk(32'(pslverr), 32'(err));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic cfg(input logic [7:0] pm, input logic [7:0] io);
    apb(1'b1, PORT_MODE_ADDR, pm | 8'h40, 8'h00, 1'b0);
    apb(1'b1, LINE_IO_ADDR, io, 8'h00, 1'b0);
    apb(1'b0, LINE_IO_ADDR, 8'h00, io & 8'h78, 1'b0);
    apb(1'b1, PORT_MODE_ADDR, pm, 8'h00, 1'b0);
    repeat (2) @(posedge clk_sys);
  endtask : cfg
  task automatic rx_wait(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rx_byte_valid !== 1'b1 && n < 300);
    chk(32'(rx_byte_valid), 32'h1);
    chk({24'h000000, rx_byte}, {24'h000000, exp});
  endtask : rx_wait
  task automatic rx_case(input logic [7:0] b, input int sync_at, input logic pol,
                         input logic fall);
    fork
      line_framer_model_i.send_rx(b, sync_at, pol, fall);
      rx_wait(b);
    join
  endtask : rx_case
  task automatic tx_case(input logic [7:0] b, input logic [7:0] exp, input int sync_at,
                         input logic pol, input logic fall, input int loads);
    int taken0;
    taken0 = n_taken;
    tx_byte_in <= b;
    line_framer_model_i.run_tx(sync_at, pol, fall);
    chk({24'h000000, line_framer_model_i.tx_seen}, {24'h000000, exp});
    chk(32'(n_taken - taken0), 32'(loads));
  endtask : tx_case
  task automatic t_defaults();
    apb(1'b0, PORT_MODE_ADDR, 8'h00, 8'h00, 1'b0);
    apb(1'b0, LINE_IO_ADDR, 8'h00, 8'h00, 1'b0);
    apb(1'b0, 8'h08, 8'h00, 8'h00, 1'b1);
  endtask : t_defaults
  task automatic t_full_reset();
    cfg(8'h15, 8'h78);
    apb(1'b1, PORT_MODE_ADDR, 8'h95, 8'h00, 1'b0);
    apb(1'b0, PORT_MODE_ADDR, 8'h00, 8'h80, 1'b0);
    apb(1'b1, LINE_IO_ADDR, 8'h78, 8'h00, 1'b0);
    apb(1'b0, LINE_IO_ADDR, 8'h00, 8'h00, 1'b0);
    chk(32'(line_tx_data_oe), 32'h0);
    apb(1'b1, PORT_MODE_ADDR, 8'h01, 8'h00, 1'b0);
    repeat (2) @(posedge clk_sys);
    chk(32'(line_mode_active), 32'h1);
  endtask : t_full_reset
  task automatic t_state_reset();
    cfg(8'h01, 8'h78);
    apb(1'b1, PORT_MODE_ADDR, 8'h41, 8'h00, 1'b0);
    apb(1'b0, PORT_MODE_ADDR, 8'h00, 8'h41, 1'b0);
    apb(1'b0, LINE_IO_ADDR, 8'h00, 8'h78, 1'b0);
    chk(32'(line_tx_data_oe), 32'h0);
  endtask : t_state_reset
  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      cfg(8'(m), 8'h00);
      chk(32'(line_mode_active), 32'(m));
      chk(32'(line_tx_data_oe), 32'(m inside {0, 1, 5, 6}));
    end
  endtask : t_modes
  task automatic t_line();
    cfg(8'h00, 8'h00);
    rx_case(8'ha5, 0, 1'b0, 1'b0);
    tx_case(8'h5a, 8'h5a, 0, 1'b0, 1'b0, 1);
    cfg(8'h00, 8'h78);
    rx_case(8'h3c, 0, 1'b1, 1'b1);
    tx_case(8'hc6, 8'hc6, 0, 1'b1, 1'b1, 1);
    cfg(8'h05, 8'h00);
    rx_case(8'h96, 3, 1'b0, 1'b0);
    tx_case(8'h69, 8'h69, 3, 1'b0, 1'b0, 1);
  endtask : t_line
  task automatic t_loops();
    cfg(8'h10, 8'h00);
    rx_case(8'hb4, 0, 1'b0, 1'b0);
    tx_case(8'h4b, 8'hb4, 0, 1'b0, 1'b0, 0);
    cfg(8'h20, 8'h00);
    chk(32'(line_mode_active), 32'(MODE_GP));
    chk(32'(line_tx_data_oe), 32'h1);
    tx_byte_in <= 8'he1;
    // The looped receiver samples at the edge that launches the next bit, so it lags one bit.
    fork
      line_framer_model_i.run_tx(3, 1'b0, 1'b0);
      rx_wait(8'h70);
    join
    chk({24'h000000, line_framer_model_i.tx_seen}, 32'h000000e1);
  endtask : t_loops
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_defaults();
    t_full_reset();
    t_state_reset();
    t_modes();
    t_line();
    t_loops();
    summarize();
  end
endmodule : port_mode_line_interface_config_tb
`default_nettype wire
